// ==== dv/boot_mode_select_bench.sv ====
// self-checking bench for boot mode selection
`timescale 1ns/10ps
module boot_mode_select_bench;
   logic        ref_clk_in = 1'b0;
   logic        rst_b_in   = 1'b0;
   logic [1:0]  strap      = 2'h0;
   logic [31:0] cfg        = 32'h0;
   logic [39:0] tbl        = 40'h0;
   wire  [31:0] pins, oe, pu;
   wire  [3:0]  mode;
   wire  [2:0]  code;
   wire         hi, lo, alt, custom, valid;
   int          miscompares = 0;
   int          n_tests     = 0;
   int          cycles      = 0;
   ////////////////////////////////////////////////////////////////////////////
   boot_strap_board boot_strap_board_inst (.strap_in(strap), .gpio_strap_in(32'h4000_0220),
      .hi_pin_out(hi), .lo_pin_out(lo), .gpio_out(pins));
   boot_mode_select #(.INIT_CYCLES(2), .NUM_GPIO(32)) boot_mode_select_inst (
      .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .boot_select_hi_pin_in(hi),
      .boot_select_lo_pin_in(lo), .gpio_in(pins), .otp_pin_cfg_in(cfg),
      .otp_table_in(tbl), .fw_pins_ready_in(1'b0), .boot_mode_out(mode),
      .alt_pins_out(alt), .custom_used_out(custom), .select_code_out(code),
      .boot_mode_valid_out(valid), .gpio_oe_out(oe), .gpio_pullup_en_out(pu));
   // clock and hang guard; a boot takes about seven cycles
   initial begin
      forever #50 ref_clk_in = ~ref_clk_in;
   end
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 1000) begin
         miscompares++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // reset for two cycles with new straps, then wait for the decision
   task automatic run_boot(input logic [1:0] s, input logic [31:0] c);
      int n;
      @(posedge ref_clk_in) rst_b_in <= 1'b0;
      strap <= s;
      cfg <= c;
      repeat (2) @(posedge ref_clk_in);
      rst_b_in <= 1'b1;
      for (n = 0; n < 50 && valid !== 1'b1; n++) @(negedge ref_clk_in);
      check("valid", 8'(valid), 8'h01);
   endtask
   task automatic t_default();
      for (int k = 0; k < 4; k++) begin
         run_boot(2'(k), 32'h0);
         check("mode", 8'(mode), 8'(k));
         check("code", 8'(code), 8'(k));
         check("alt", 8'(alt), 8'h00);
         check("custom", 8'(custom), 8'h00);
         check("drive", 8'(|{oe, pu}), 8'h00);
         @(posedge ref_clk_in) strap <= 2'(~k);
         repeat (3) @(negedge ref_clk_in);
         check("held", 8'(mode), 8'(k));
         check("held code", 8'(code), 8'(k));
      end
      $display("test default done");
   endtask
   // selectors on pins 5, 9, 30, all strapped high: code has a one for each active selector
   task automatic t_custom();
      int idx;
      for (int c = 0; c < 4; c++) begin
         idx = (1 << c) - 1;
         run_boot(2'h3, {14'h0, 1'b1, 5'd30, 5'd9, 5'd5, 2'(c)});
         check("code", 8'(code), 8'(idx));
         check("tmode", 8'(mode), 8'((3 * idx + 1) % 16));
         check("alt", 8'(alt), 8'((3 * idx + 1) / 16));
         check("custom", 8'(custom), 8'h01);
      end
      $display("test custom done");
   endtask
   task automatic print_verdict();
      $display("checks %0d miscompares %0d", n_tests, miscompares);
      if (miscompares == 0 && n_tests > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      for (int i = 0; i < 8; i++) tbl[5*i +: 5] = 5'(3 * i + 1);
      t_default();
      t_custom();
      print_verdict();
   end
endmodule

// ==== dv/boot_mode_select_monitor.sv ====
// checker for the boot mode selection ports
`timescale 1ns/10ps
module boot_mode_select_monitor #(
   parameter INIT_CYCLES = 20,
   parameter NUM_GPIO    = 32
) (
   input wire logic                ref_clk_in,
   input wire logic                rst_b_in,
   input wire logic                boot_select_hi_pin_in,
   input wire logic                boot_select_lo_pin_in,
   input wire logic [31:0]         otp_pin_cfg_in,
   input wire logic [39:0]         otp_table_in,
   input wire logic [3:0]          boot_mode_out,
   input wire logic                alt_pins_out,
   input wire logic                custom_used_out,
   input wire logic [2:0]          select_code_out,
   input wire logic                boot_mode_valid_out,
   input wire logic [NUM_GPIO-1:0] gpio_oe_out,
   input wire logic [NUM_GPIO-1:0] gpio_pullup_en_out
);
   localparam int WAIT_N = INIT_CYCLES + 1;
   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   // init count runs out before the decision shows
   sequence s_counting;
      ##WAIT_N !boot_mode_valid_out;
   endsequence
   sequence s_decided;
      $rose(boot_mode_valid_out);
   endsequence
   ////////////////////////////////////////////////////////////////////////////
   init_wait_a: assert property ($rose(rst_b_in) |-> s_counting ##1 boot_mode_valid_out)
      else $error("decision not on time");
   oe_off_a: assert property (gpio_oe_out == '0)
      else $error("pin driven during boot");
   pulls_off_a: assert property (gpio_pullup_en_out == '0)
      else $error("pull-up enabled during boot");
   result_hold_a: assert property (boot_mode_valid_out |=> boot_mode_valid_out
      && $stable({boot_mode_out, alt_pins_out, custom_used_out, select_code_out}))
      else $error("decision changed");
   default_mode_a: assert property (s_decided ##0 !custom_used_out |->
      boot_mode_out == {2'b00, select_code_out[1:0]} && select_code_out ==
      {1'b0, $past(boot_select_hi_pin_in, 2), $past(boot_select_lo_pin_in, 2)})
      else $error("default decode wrong");
   custom_flag_a: assert property (s_decided |->
      custom_used_out == $past(otp_pin_cfg_in[17], 2))
      else $error("custom use flag wrong");
   table_mode_a: assert property (s_decided ##0 custom_used_out |->
      boot_mode_out == 4'($past(otp_table_in, 2) >> (5 * select_code_out)))
      else $error("table mode wrong");
   table_alt_a: assert property (s_decided ##0 custom_used_out |->
      alt_pins_out == 1'($past(otp_table_in, 2) >> (5 * select_code_out + 4)))
      else $error("alternate pin flag wrong");
endmodule
bind boot_mode_select boot_mode_select_monitor #(.INIT_CYCLES(INIT_CYCLES),
   .NUM_GPIO(NUM_GPIO)) monitor_inst (.*);

// ==== dv/boot_strap_board.sv ====
// board straps: pull resistors holding the select pins
`timescale 1ns/10ps
module boot_strap_board (
   input  wire logic [1:0]  strap_in,
   input  wire logic [31:0] gpio_strap_in,
   output wire logic        hi_pin_out,
   output wire logic        lo_pin_out,
   output wire logic [31:0] gpio_out
);
   // pulls give a defined level; nothing else drives the pins in boot
   assign {hi_pin_out, lo_pin_out} = strap_in;
   assign gpio_out = gpio_strap_in;
endmodule

// ==== hdl/boot_mode_regs.vh ====
// constants for the boot mode selection logic
`ifndef BOOT_MODE_REGS_VH
`define BOOT_MODE_REGS_VH
// boot mode codes
`define BOOT_MODE_PARALLEL  4'h0
`define BOOT_MODE_SERIAL    4'h1
`define BOOT_MODE_CAN       4'h2
`define BOOT_MODE_FLASH     4'h3
`define BOOT_MODE_I2C       4'h4
`define BOOT_MODE_SPI       4'h5
`define BOOT_MODE_FD_CAN    4'h6
// otp field layout: word0 = pin config, word1 = table (8 x 5 bits)
`define OTP_PINS_LSB        0
`define OTP_PINS_W          2
`define OTP_SEL0_LSB        2
`define OTP_SEL1_LSB        7
`define OTP_SEL2_LSB        12
`define OTP_SEL_W           5
`define OTP_VALID_BIT       17
`define OTP_ENTRY_W         5
`define OTP_ENTRY_ALT_BIT   4
// initialization time before sampling
`define INIT_TIME_NS        2000
`define CLK_PERIOD_NS       100
`define INIT_CYCLES         ((`INIT_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ==== hdl/boot_mode_select.v ====
// boot mode selection: sample strap pins after init, pick boot source
`timescale 1ns/10ps
`include "boot_mode_regs.vh"
module boot_mode_select #(
   parameter INIT_CYCLES = `INIT_CYCLES,
   parameter NUM_GPIO    = 32
) (
   input  wire                ref_clk_in,
   input  wire                rst_b_in,
   input  wire                boot_select_hi_pin_in,
   input  wire                boot_select_lo_pin_in,
   input  wire [NUM_GPIO-1:0] gpio_in,
   input  wire [31:0]         otp_pin_cfg_in,
   input  wire [39:0]         otp_table_in,
   input  wire                fw_pins_ready_in,
   output reg  [3:0]          boot_mode_out,
   output reg                 alt_pins_out,
   output reg                 custom_used_out,
   output reg  [2:0]          select_code_out,
   output reg                 boot_mode_valid_out,
   output reg  [NUM_GPIO-1:0] gpio_oe_out,
   output reg  [NUM_GPIO-1:0] gpio_pullup_en_out
);
   // sequence states; one decision per reset, only reset starts another
   localparam ST_INIT   = 2'h0;
   localparam ST_SAMPLE = 2'h1;
   localparam ST_DONE   = 2'h2;

   // sequencer, captured copy of straps and otp, decoder results
   reg  [1:0]  state;
   reg  [15:0] init_cnt;
   reg         custom_en;
   reg  [1:0]  pin_count;
   reg  [2:0]  code;
   reg  [39:0] table_q;
   wire [3:0]  dec_mode;
   wire        dec_alt;
   reg  [2:0]  next_code;
   reg  [1:0]  next_state;
   reg  [15:0] next_init_cnt;
   wire [15:0] init_last;
   wire        init_done;
   wire        capture;
   wire        publish;
   wire        cfg_valid;
   wire [1:0]  cfg_count;

   // pick one gpio bit by an otp select index
   function sel_bit;
      input [NUM_GPIO-1:0] pins;
      input [4:0]          sel;
      begin
         // an index past the last pin reads low rather than unknown
         sel_bit = (sel < NUM_GPIO) ? pins[sel] : 1'b0;
      end
   endfunction

   // gpio index held in the otp select field of selector k
   function [4:0] sel_index;
      input [31:0] cfg;
      input [1:0]  k;
      begin
         sel_index = cfg[`OTP_SEL0_LSB + k * `OTP_SEL_W +: `OTP_SEL_W];
      end
   endfunction

   // selector k takes part when the programmed count exceeds k
   function pin_active;
      input [1:0] count;
      input [1:0] k;
      begin
         pin_active = (count > k);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // otp fields; an unprogrammed part keeps the factory pair
   assign cfg_valid = otp_pin_cfg_in[`OTP_VALID_BIT];
   assign cfg_count = otp_pin_cfg_in[`OTP_PINS_LSB +: `OTP_PINS_W];

   // code to sample: custom pins when otp valid, else default pair
   // unused selector bits read zero so the table index stays in range
   // custom selectors may sit on any pin, hence the whole pin bus
   always @* begin
      next_code = {1'b0, boot_select_hi_pin_in, boot_select_lo_pin_in};
      if (cfg_valid) begin
         next_code[0] = pin_active(cfg_count, 2'h0) &
            sel_bit(gpio_in, sel_index(otp_pin_cfg_in, 2'h0));
         next_code[1] = pin_active(cfg_count, 2'h1) &
            sel_bit(gpio_in, sel_index(otp_pin_cfg_in, 2'h1));
         next_code[2] = pin_active(cfg_count, 2'h2) &
            sel_bit(gpio_in, sel_index(otp_pin_cfg_in, 2'h2));
      end
   end

   // decode works on the captured copy, never on the live pins
   boot_table_decode u_decode (
      .custom_en_in (custom_en),
      .pin_count_in (pin_count),
      .code_in      (code),
      .table_in     (table_q),
      .mode_out     (dec_mode),
      .alt_pins_out (dec_alt)
   );

   ////////////////////////////////////////////////////////////////////
   // sequence: wait init, sample once, publish, then hold until reset
   // a zero init time must not wrap into a very long wait
   assign init_last = (INIT_CYCLES == 0) ? 16'h0000 : INIT_CYCLES[15:0] - 16'h0001;
   assign init_done = (init_cnt >= init_last);

   // one capture edge, right after the init wait
   assign capture = (state == ST_SAMPLE);

   // results load once; the valid flag then blocks any reload
   assign publish = (state == ST_DONE) && !boot_mode_valid_out;

   // next state; the done state is terminal until the next reset
   always @* begin
      next_state = state;
      case (state)
         ST_INIT: begin
            if (init_done) begin
               next_state = ST_SAMPLE;
            end
         end
         ST_SAMPLE: begin
            next_state = ST_DONE;
         end
         ST_DONE: begin
            next_state = ST_DONE;
         end
         default: begin
            next_state = ST_INIT; // unused code recovers through init
         end
      endcase
   end

   // state register
   always @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         state <= ST_INIT;
      end else begin
         state <= next_state;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // init counter; stops at its end value so it never wraps
   always @* begin
      next_init_cnt = init_cnt;
      if ((state == ST_INIT) && !init_done) begin
         next_init_cnt = init_cnt + 16'h0001;
      end
   end

   always @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         init_cnt <= 16'h0000;
      end else begin
         init_cnt <= next_init_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // capture once; later pin and otp changes are ignored
   always @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         custom_en <= 1'b0;
         pin_count <= 2'h0;
         code <= 3'h0;
         table_q <= 40'h0000000000;
      end else if (capture) begin
         code <= next_code;
         custom_en <= cfg_valid;
         pin_count <= cfg_count;
         table_q <= otp_table_in;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // publish the decision once; outputs then hold until reset
   always @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         boot_mode_out <= 4'h0;
         alt_pins_out <= 1'b0;
         custom_used_out <= 1'b0;
         select_code_out <= 3'h0;
         boot_mode_valid_out <= 1'b0;
      end else if (publish) begin
         boot_mode_out <= dec_mode;
         alt_pins_out <= dec_alt;
         custom_used_out <= custom_en;
         select_code_out <= code;
         boot_mode_valid_out <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // pins stay inputs without pulls; the board alone sets strap levels
   // firmware readiness changes nothing here: pin muxing lives elsewhere
   always @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         gpio_oe_out <= {NUM_GPIO{1'b0}};
         gpio_pullup_en_out <= {NUM_GPIO{1'b0}};
      end else if (fw_pins_ready_in && (state == ST_DONE)) begin
         gpio_oe_out <= {NUM_GPIO{1'b0}};
         gpio_pullup_en_out <= {NUM_GPIO{1'b0}};
      end
   end
endmodule

// ==== hdl/boot_table_decode.v ====
// decode of a sampled select code into a boot mode
`timescale 1ns/10ps
`include "boot_mode_regs.vh"
module boot_table_decode (
   input  wire        custom_en_in,
   input  wire [1:0]  pin_count_in,
   input  wire [2:0]  code_in,
   input  wire [39:0] table_in,
   output reg  [3:0]  mode_out,
   output reg         alt_pins_out
);
   reg [2:0] idx;
   reg [4:0] entry;
   // default map is identity of the two-bit code; custom map indexes the table
   always @* begin
      idx = 3'h0;
      entry = 5'h00;
      mode_out = {2'h0, code_in[1:0]};
      alt_pins_out = 1'b0;
      if (custom_en_in) begin
         case (pin_count_in)
            2'h0: idx = 3'h0;
            2'h1: idx = {2'h0, code_in[0]};
            2'h2: idx = {1'h0, code_in[1:0]};
            default: idx = code_in;
         endcase
         entry = table_in[idx*5 +: 5];
         mode_out = entry[3:0];
         alt_pins_out = entry[`OTP_ENTRY_ALT_BIT];
      end
   end
endmodule
